// [core/tpq_cfg.svh]
/*
  Constants of the three-phase PWM and quadrature timer: register
  offsets, control and status bit positions, reset values.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef TPQ_CFG_SVH
`define TPQ_CFG_SVH

`define TPQ_AW              8
`define TPQ_OFF_CTRL        8'h00
`define TPQ_OFF_MAIN_CNT    8'h04
`define TPQ_OFF_OFFSET_CNT  8'h08
`define TPQ_OFF_PERIOD      8'h0C
`define TPQ_OFF_EDGE1       8'h10
`define TPQ_OFF_EDGE2       8'h14
`define TPQ_OFF_EDGE3       8'h18
`define TPQ_OFF_BUF1        8'h1C
`define TPQ_OFF_BUF2        8'h20
`define TPQ_OFF_BUF3        8'h24
`define TPQ_OFF_STATUS      8'h28
`define TPQ_OFF_QUAD_CNT    8'h2C
`define TPQ_OFF_QUAD_CMP_A  8'h30
`define TPQ_OFF_QUAD_CMP_B  8'h34
`define TPQ_OFF_QUAD_IRQ_EN 8'h38

`define TPQ_CTRL_MODE_LO    0
`define TPQ_CTRL_MODE_HI    1
`define TPQ_CTRL_BUF_EN     2
`define TPQ_CTRL_RUN_MAIN   3
`define TPQ_CTRL_RUN_OFFSET 4
`define TPQ_CTRL_QUAD_RUN   5
`define TPQ_CTRL_PHASE_MODE 6
`define TPQ_CTRL_OLS1       8
`define TPQ_CTRL_OLS23      9
`define TPQ_CTRL_CLR_LO     10
`define TPQ_CTRL_CLR_HI     11
`define TPQ_CTRL_PSC_LO     12
`define TPQ_CTRL_PSC_HI     13
`define TPQ_CTRL_MASK       16'h3F7F

`define TPQ_ST_MATCH_A      0
`define TPQ_ST_WRAP         1
`define TPQ_ST_QCMP_A       4
`define TPQ_ST_QCMP_B       5
`define TPQ_ST_QWRAP        6
`define TPQ_ST_QLO          4
`define TPQ_ST_QHI          6

`define TPQ_RST_CTRL        16'h0300
`define TPQ_RST_CNT         16'h0000
`define TPQ_RST_REG         16'hFFFF
`define TPQ_CNT_MAX         16'hFFFF
`define TPQ_CNT_ONE         16'h0001

`endif

// [core/tpq_pkg.sv]
/*
  Types of the three-phase PWM and quadrature timer.
  Assumes tpq_cfg.svh on the include path.
*/
`include "tpq_cfg.svh"

package tpq_pkg;

  typedef enum logic [1:0] {
    TPQ_MODE_FREE  = 2'b00,
    TPQ_MODE_RSYNC = 2'b01,
    TPQ_MODE_COMP  = 2'b10,
    TPQ_MODE_RSVD  = 2'b11
  } tpq_mode_e;

  typedef enum logic [1:0] {
    TPQ_CLR_NONE = 2'b00,
    TPQ_CLR_CMPA = 2'b01,
    TPQ_CLR_CMPB = 2'b10,
    TPQ_CLR_RSVD = 2'b11
  } tpq_clr_e;

  typedef struct packed {
    logic p1;
    logic p1_n;
    logic p2;
    logic p2_n;
    logic p3;
    logic p3_n;
  } tpq_pwm_s;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic       up;
    logic       dn;
  } tpq_qdec_s;

  typedef struct packed {
    logic [15:0]      ctrl;
    logic [15:0]      main_cnt;
    logic [15:0]      off_cnt;
    logic [15:0]      period;
    logic [2:0][15:0] edge_r;
    logic [2:0][15:0] buf_r;
    logic [15:0]      quad_cnt;
    logic [15:0]      quad_cmp_a;
    logic [15:0]      quad_cmp_b;
    logic [2:0]       irq_en;
    logic [7:0]       status;
    logic             dir_down;
    logic [2:0]       pos_raw;
    logic [2:0]       neg_raw;
    tpq_pwm_s         pwm;
    logic [2:0]       presc;
    logic             quad_req;
    logic [31:0]      rdata;
  } tpq_state_s;

endpackage : tpq_pkg

// [core/tpq_quad_decoder.sv]
/*
  Quadrature edge decoder: synchronises the two phase inputs and emits
  one-cycle up or down step pulses on every valid edge.
  Assumes phase inputs asynchronous to pclk, widths kept by the encoder.
*/
`timescale 1ns/1ns

module tpq_quad_decoder (
  input  wire logic pclk,      // System clock
  input  wire logic presetn,   // Async reset, active low
  input  wire logic ce,        // Clock enable
  input  wire logic quad_in_a, // Phase A pin
  input  wire logic quad_in_b, // Phase B pin
  output logic      step_up,   // Count up pulse
  output logic      step_dn    // Count down pulse
);

  tpq_pkg::tpq_qdec_s st_ff;
  tpq_pkg::tpq_qdec_s nxt_st;

  logic a;
  logic b;
  logic pa;
  logic pb;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = {quad_in_a, quad_in_b};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;
    a  = st_ff.sync2[1];
    b  = st_ff.sync2[0];
    pa = st_ff.prev[1];
    pb = st_ff.prev[0];
    // Both edges of both phases counted; double change ignored
    nxt_st.up = ((b & ~pb & ~a) | (a & ~pa & b) |
                 (~b & pb & a) | (~a & pa & ~b)) &
                ((a ^ pa) ^ (b ^ pb));
    nxt_st.dn = ((b & ~pb & a) | (a & ~pa & ~b) |
                 (~b & pb & ~a) | (~a & pa & b)) &
                ((a ^ pa) ^ (b ^ pb));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign step_up = st_ff.up;
  assign step_dn = st_ff.dn;

endmodule : tpq_quad_decoder

// [core/tpq_timer.sv]
/*
  Three-phase PWM timer with a quadrature counter channel, APB slave.
  Holds control, counters, edge and buffer registers, status flags and
  the six phase outputs. Assumes one pclk domain and an APB master.
*/
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "tpq_cfg.svh"

// Functional notes
// - Reset-sync mode drives three complementary output pairs
// - Reset-sync: main counts up, clears at period
// - Outputs toggle on own match and at clear
// - Reset-sync: offset counter runs detached from compares
// - Phase1 edge and second channel compares set edges
// - Complementary: both count up/down, turn at limits
// - Compare order main, offset, offset, main
// - Three phases from three edge register matches
// - Edge above period: no match, fixed duty
// - Match-A flag only on up-count period match
// - Offset wrap flag on complementary underflow, in other modes on overflow
// - Buffers copy at period match and underflow
// - Phase inputs clock quadrature counter, override prescale
// - Quadrature clear, compare, flags, enables still work
// - Count both edges of both phase inputs
// - Level select bits set output polarity
module tpq_timer (
  input  wire logic                 pclk,      // System clock
  input  wire logic                 presetn,   // Async reset, active low
  input  wire logic                 ce,        // Clock enable
  input  wire logic                 psel,      // APB select
  input  wire logic                 penable,   // APB enable
  input  wire logic                 pwrite,    // APB write
  input  wire logic [`TPQ_AW-1:0]   paddr,     // APB byte address
  input  wire logic [31:0]          pwdata,    // APB write data
  output logic      [31:0]          prdata,    // APB read data
  output logic                      pready,    // APB ready
  output logic                      pslverr,   // Unmapped address
  input  wire logic                 quad_in_a, // Encoder phase A
  input  wire logic                 quad_in_b, // Encoder phase B
  output tpq_pkg::tpq_pwm_s         pwm,       // Six phase outputs
  output logic                      quad_req   // Quad flag request
);

  tpq_pkg::tpq_state_s st_ff;
  tpq_pkg::tpq_state_s nxt_st;
  tpq_pkg::tpq_mode_e  mode;
  tpq_pkg::tpq_clr_e   clr_sel;

  logic        step_up;
  logic        step_dn;
  logic        wr_acc;
  logic        rd_setup;
  logic        addr_ok;
  logic [7:0]  set_vec;
  logic        xfer;
  logic        main_end;
  logic        step;
  logic        tick;
  logic        hit_a;
  logic        hit_b;
  logic [2:0]  psc_mask;
  logic [15:0] wdat;
  logic [31:0] rmux;

  tpq_quad_decoder u_qdec (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .quad_in_a (quad_in_a),
    .quad_in_b (quad_in_b),
    .step_up   (step_up),
    .step_dn   (step_dn)
  );

  function automatic logic edge_hit(input logic [15:0] cnt,
                                    input logic [15:0] edg,
                                    input logic [15:0] per);
    return (cnt == edg) && (edg <= per);
  endfunction : edge_hit

  always_comb begin
    unique case (paddr)
      `TPQ_OFF_CTRL, `TPQ_OFF_MAIN_CNT, `TPQ_OFF_OFFSET_CNT,
      `TPQ_OFF_PERIOD, `TPQ_OFF_EDGE1, `TPQ_OFF_EDGE2, `TPQ_OFF_EDGE3,
      `TPQ_OFF_BUF1, `TPQ_OFF_BUF2, `TPQ_OFF_BUF3, `TPQ_OFF_STATUS,
      `TPQ_OFF_QUAD_CNT, `TPQ_OFF_QUAD_CMP_A, `TPQ_OFF_QUAD_CMP_B,
      `TPQ_OFF_QUAD_IRQ_EN: addr_ok = 1'b1;
      default:              addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rmux = 32'h0000_0000;
    unique case (paddr)
      `TPQ_OFF_CTRL:        rmux[15:0] = st_ff.ctrl;
      `TPQ_OFF_MAIN_CNT:    rmux[15:0] = st_ff.main_cnt;
      `TPQ_OFF_OFFSET_CNT:  rmux[15:0] = st_ff.off_cnt;
      `TPQ_OFF_PERIOD:      rmux[15:0] = st_ff.period;
      `TPQ_OFF_EDGE1:       rmux[15:0] = st_ff.edge_r[0];
      `TPQ_OFF_EDGE2:       rmux[15:0] = st_ff.edge_r[1];
      `TPQ_OFF_EDGE3:       rmux[15:0] = st_ff.edge_r[2];
      `TPQ_OFF_BUF1:        rmux[15:0] = st_ff.buf_r[0];
      `TPQ_OFF_BUF2:        rmux[15:0] = st_ff.buf_r[1];
      `TPQ_OFF_BUF3:        rmux[15:0] = st_ff.buf_r[2];
      `TPQ_OFF_STATUS:      rmux[7:0]  = st_ff.status;
      `TPQ_OFF_QUAD_CNT:    rmux[15:0] = st_ff.quad_cnt;
      `TPQ_OFF_QUAD_CMP_A:  rmux[15:0] = st_ff.quad_cmp_a;
      `TPQ_OFF_QUAD_CMP_B:  rmux[15:0] = st_ff.quad_cmp_b;
      `TPQ_OFF_QUAD_IRQ_EN: rmux[2:0]  = st_ff.irq_en;
      default:              rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st   = st_ff;
    set_vec  = 8'h00;
    xfer     = 1'b0;
    step     = 1'b0;
    tick     = 1'b0;
    hit_a    = 1'b0;
    hit_b    = 1'b0;
    psc_mask = 3'h0;
    wr_acc   = psel & penable & pwrite;
    rd_setup = psel & ~penable;
    wdat     = pwdata[15:0];
    mode     = tpq_pkg::tpq_mode_e'(
                 st_ff.ctrl[`TPQ_CTRL_MODE_HI:`TPQ_CTRL_MODE_LO]);
    clr_sel  = tpq_pkg::tpq_clr_e'(
                 st_ff.ctrl[`TPQ_CTRL_CLR_HI:`TPQ_CTRL_CLR_LO]);
    main_end = (st_ff.main_cnt == st_ff.period);

    // Main and offset counters by mode
    unique case (mode)
      tpq_pkg::TPQ_MODE_RSYNC: begin
        if (st_ff.ctrl[`TPQ_CTRL_RUN_MAIN]) begin
          if (main_end) begin
            nxt_st.main_cnt = `TPQ_RST_CNT;
            nxt_st.pos_raw  = ~st_ff.pos_raw;
            set_vec[`TPQ_ST_MATCH_A] = 1'b1;
            xfer = 1'b1;
          end else begin
            nxt_st.main_cnt = st_ff.main_cnt + `TPQ_CNT_ONE;
            for (int i = 0; i < 3; i++) begin
              if (edge_hit(st_ff.main_cnt, st_ff.edge_r[i],
                           st_ff.period)) begin
                nxt_st.pos_raw[i] = ~st_ff.pos_raw[i];
              end
            end
          end
        end
        nxt_st.neg_raw = ~nxt_st.pos_raw;
        if (st_ff.ctrl[`TPQ_CTRL_RUN_OFFSET]) begin
          nxt_st.off_cnt = st_ff.off_cnt + `TPQ_CNT_ONE;
          if (st_ff.off_cnt == `TPQ_CNT_MAX) begin
            set_vec[`TPQ_ST_WRAP] = 1'b1;
          end
        end
      end
      tpq_pkg::TPQ_MODE_COMP: begin
        if (st_ff.ctrl[`TPQ_CTRL_RUN_MAIN]) begin
          if (!st_ff.dir_down && main_end) begin
            nxt_st.dir_down = 1'b1;
            nxt_st.main_cnt = st_ff.main_cnt - `TPQ_CNT_ONE;
            nxt_st.off_cnt  = st_ff.off_cnt - `TPQ_CNT_ONE;
            set_vec[`TPQ_ST_MATCH_A] = 1'b1;
            xfer = 1'b1;
          end else if (st_ff.dir_down &&
                       st_ff.off_cnt == `TPQ_RST_CNT) begin
            nxt_st.dir_down = 1'b0;
            nxt_st.main_cnt = st_ff.main_cnt + `TPQ_CNT_ONE;
            nxt_st.off_cnt  = st_ff.off_cnt + `TPQ_CNT_ONE;
            set_vec[`TPQ_ST_WRAP] = 1'b1;
            xfer = 1'b1;
          end else if (st_ff.dir_down) begin
            nxt_st.main_cnt = st_ff.main_cnt - `TPQ_CNT_ONE;
            nxt_st.off_cnt  = st_ff.off_cnt - `TPQ_CNT_ONE;
          end else begin
            nxt_st.main_cnt = st_ff.main_cnt + `TPQ_CNT_ONE;
            nxt_st.off_cnt  = st_ff.off_cnt + `TPQ_CNT_ONE;
          end
          // Main ahead of offset gives the dead-time gap
          for (int i = 0; i < 3; i++) begin
            if (edge_hit(st_ff.main_cnt, st_ff.edge_r[i],
                         st_ff.period)) begin
              nxt_st.pos_raw[i] = st_ff.dir_down;
            end
            if (edge_hit(st_ff.off_cnt, st_ff.edge_r[i],
                         st_ff.period)) begin
              nxt_st.neg_raw[i] = ~st_ff.dir_down;
            end
          end
        end
      end
      default: begin
        // Free running up counters, no waveform
        if (st_ff.ctrl[`TPQ_CTRL_RUN_MAIN]) begin
          nxt_st.main_cnt = st_ff.main_cnt + `TPQ_CNT_ONE;
          if (main_end) begin
            set_vec[`TPQ_ST_MATCH_A] = 1'b1;
          end
        end
        if (st_ff.ctrl[`TPQ_CTRL_RUN_OFFSET]) begin
          nxt_st.off_cnt = st_ff.off_cnt + `TPQ_CNT_ONE;
          if (st_ff.off_cnt == `TPQ_CNT_MAX) begin
            set_vec[`TPQ_ST_WRAP] = 1'b1;
          end
        end
      end
    endcase

    if (xfer && st_ff.ctrl[`TPQ_CTRL_BUF_EN]) begin
      nxt_st.edge_r = st_ff.buf_r;
    end

    // Quadrature channel
    unique case (st_ff.ctrl[`TPQ_CTRL_PSC_HI:`TPQ_CTRL_PSC_LO])
      2'h0:    psc_mask = 3'h0;
      2'h1:    psc_mask = 3'h1;
      2'h2:    psc_mask = 3'h3;
      default: psc_mask = 3'h7;
    endcase
    if (st_ff.ctrl[`TPQ_CTRL_QUAD_RUN]) begin
      if (st_ff.ctrl[`TPQ_CTRL_PHASE_MODE]) begin
        step = step_up | step_dn;
      end else begin
        nxt_st.presc = st_ff.presc + 3'h1;
        tick = ((st_ff.presc & psc_mask) == psc_mask);
        step = tick;
      end
    end
    if (step) begin
      hit_a = (st_ff.quad_cnt == st_ff.quad_cmp_a);
      hit_b = (st_ff.quad_cnt == st_ff.quad_cmp_b);
      set_vec[`TPQ_ST_QCMP_A] = hit_a;
      set_vec[`TPQ_ST_QCMP_B] = hit_b;
      if ((clr_sel == tpq_pkg::TPQ_CLR_CMPA && hit_a) ||
          (clr_sel == tpq_pkg::TPQ_CLR_CMPB && hit_b)) begin
        nxt_st.quad_cnt = `TPQ_RST_CNT;
      end else if (st_ff.ctrl[`TPQ_CTRL_PHASE_MODE] && step_dn) begin
        nxt_st.quad_cnt = st_ff.quad_cnt - `TPQ_CNT_ONE;
        set_vec[`TPQ_ST_QWRAP] = (st_ff.quad_cnt == `TPQ_RST_CNT);
      end else begin
        nxt_st.quad_cnt = st_ff.quad_cnt + `TPQ_CNT_ONE;
        set_vec[`TPQ_ST_QWRAP] = (st_ff.quad_cnt == `TPQ_CNT_MAX);
      end
    end

    // Register writes take the access edge; they beat counting
    if (wr_acc) begin
      unique case (paddr)
        `TPQ_OFF_CTRL:        nxt_st.ctrl = wdat & `TPQ_CTRL_MASK;
        `TPQ_OFF_MAIN_CNT:    nxt_st.main_cnt = wdat;
        `TPQ_OFF_OFFSET_CNT:  nxt_st.off_cnt = wdat;
        `TPQ_OFF_PERIOD:      nxt_st.period = wdat;
        `TPQ_OFF_EDGE1:       nxt_st.edge_r[0] = wdat;
        `TPQ_OFF_EDGE2:       nxt_st.edge_r[1] = wdat;
        `TPQ_OFF_EDGE3:       nxt_st.edge_r[2] = wdat;
        `TPQ_OFF_BUF1:        nxt_st.buf_r[0] = wdat;
        `TPQ_OFF_BUF2:        nxt_st.buf_r[1] = wdat;
        `TPQ_OFF_BUF3:        nxt_st.buf_r[2] = wdat;
        `TPQ_OFF_QUAD_CNT:    nxt_st.quad_cnt = wdat;
        `TPQ_OFF_QUAD_CMP_A:  nxt_st.quad_cmp_a = wdat;
        `TPQ_OFF_QUAD_CMP_B:  nxt_st.quad_cmp_b = wdat;
        `TPQ_OFF_QUAD_IRQ_EN: nxt_st.irq_en = pwdata[2:0];
        default:              nxt_st.ctrl = nxt_st.ctrl;
      endcase
    end
    // Writing 0 clears a flag; a new event wins
    if (wr_acc && paddr == `TPQ_OFF_STATUS) begin
      nxt_st.status = (st_ff.status & pwdata[7:0]) | set_vec;
    end else begin
      nxt_st.status = st_ff.status | set_vec;
    end

    nxt_st.quad_req = |(nxt_st.status[`TPQ_ST_QHI:`TPQ_ST_QLO] &
                        nxt_st.irq_en);

    // Level select 1 passes the waveform, 0 inverts it
    nxt_st.pwm.p1   = nxt_st.pos_raw[0] ~^ nxt_st.ctrl[`TPQ_CTRL_OLS1];
    nxt_st.pwm.p1_n = nxt_st.neg_raw[0] ~^ nxt_st.ctrl[`TPQ_CTRL_OLS1];
    nxt_st.pwm.p2   = nxt_st.pos_raw[1] ~^ nxt_st.ctrl[`TPQ_CTRL_OLS23];
    nxt_st.pwm.p2_n = nxt_st.neg_raw[1] ~^ nxt_st.ctrl[`TPQ_CTRL_OLS23];
    nxt_st.pwm.p3   = nxt_st.pos_raw[2] ~^ nxt_st.ctrl[`TPQ_CTRL_OLS23];
    nxt_st.pwm.p3_n = nxt_st.neg_raw[2] ~^ nxt_st.ctrl[`TPQ_CTRL_OLS23];

    if (rd_setup) begin
      nxt_st.rdata = rmux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff            <= '0;
      st_ff.ctrl       <= `TPQ_RST_CTRL;
      st_ff.period     <= `TPQ_RST_REG;
      st_ff.edge_r     <= {3{`TPQ_RST_REG}};
      st_ff.buf_r      <= {3{`TPQ_RST_REG}};
      st_ff.quad_cmp_a <= `TPQ_RST_REG;
      st_ff.quad_cmp_b <= `TPQ_RST_REG;
      st_ff.pwm        <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign pready   = psel & penable & ce;
  assign pslverr  = psel & penable & ce & ~addr_ok;
  assign prdata   = st_ff.rdata;
  assign pwm      = st_ff.pwm;
  assign quad_req = st_ff.quad_req;

endmodule : tpq_timer

// [testbench/testbench.sv]
/*
  Self-checking bench of tpq_timer: registers, quadrature, both PWM modes.
  Assumes tpq_pkg, the encoder model and the checker compiled first.
*/
`timescale 1ns/1ns
`include "tpq_cfg.svh"

module testbench;
  logic               pclk, presetn, ce, psel, penable, pwrite;
  logic [`TPQ_AW-1:0] paddr;
  logic [31:0]        pwdata, prdata, d;
  logic               pready, pslverr, quad_req, quad_in_a, quad_in_b;
  logic               step, dir_up, busy, ce_rnd;
  logic [5:0]         pv;
  logic [1:0]         c2;
  tpq_pkg::tpq_pwm_s  pwm;
  logic [31:0]        exp_q[$];
  logic [15:0]        rst_v[15];
  int                 ev[3], cv[3];
  int                 miscompares, total_checks, seed, per, hi, hin, i;

  tpq_timer u_tpq_timer (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .quad_in_a, .quad_in_b,
    .pwm, .quad_req);
  tpq_enc_model #(.HOLD(4)) u_tpq_enc_model (.pclk, .step, .dir_up,
    .quad_in_a, .quad_in_b, .busy);
  assign pv = pwm;

  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      ce <= ce_rnd ? 1'($random(seed)) : 1'b1;
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    ce <= 1'b1;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic enc(input logic up, input int k);
    repeat (k) begin
      step <= 1'b1;
      dir_up <= up;
      @(posedge pclk);
      step <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : enc

  // One full cycle of a phase output: period and high time
  task automatic meas(input int b, output int p, output int h);
    int n;
    n = 0;
    p = 0;
    h = 0;
    while (pv[b] !== 1'b0 && n < 200) begin @(posedge pclk); n++; end
    while (pv[b] !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
    p = n;
    while (pv[b] === 1'b1 && n < 200) begin @(posedge pclk); n++; h++; end
    while (pv[b] !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
    p = n - p;
    if (n >= 200) miscompares++;
  endtask : meas

  // Read data compared against the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk(prdata, exp_q.pop_front());
  end

  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {ce, psel, penable, pwrite, step, dir_up, ce_rnd} = 7'h40;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h0038;
    rst_v = '{16'h0300, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF,
      16'hFFFF, 16'h0000};
    ev = '{2, 5, 7};
    cv = '{5, 10, 3};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 15; i++) rd(8'(i * 4), {16'h0000, rst_v[i]});
    rd(8'h3C, 32'h0);
    ce_rnd = 1'b1;
    for (i = 3; i < 14; i++) begin
      d = $random(seed);
      if (i != 10) apb(1'b1, 8'(i * 4), d);
      if (i != 10) rd(8'(i * 4), {16'h0000, d[15:0]});
    end
    apb(1'b1, 8'h40, d);
    rd(8'h40, 32'h0);
    ce_rnd = 1'b0;
    $display("register test done");
    apb(1'b1, `TPQ_OFF_QUAD_CNT, 32'h0);
    apb(1'b1, `TPQ_OFF_QUAD_CMP_A, 32'h6);
    apb(1'b1, `TPQ_OFF_QUAD_CMP_B, 32'hFFFF);
    apb(1'b1, `TPQ_OFF_QUAD_IRQ_EN, 32'h1);
    apb(1'b1, `TPQ_OFF_CTRL, 32'h3360);
    apb(1'b1, `TPQ_OFF_STATUS, 32'h0);
    enc(1'b1, 8);
    rd(`TPQ_OFF_QUAD_CNT, 32'h8);
    rd(`TPQ_OFF_STATUS, 32'h10);
    chk({31'h0, quad_req}, 32'h1);
    apb(1'b1, `TPQ_OFF_QUAD_IRQ_EN, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, quad_req}, 32'h0);
    enc(1'b0, 3);
    rd(`TPQ_OFF_QUAD_CNT, 32'h5);
    apb(1'b1, `TPQ_OFF_CTRL, 32'h3760);
    enc(1'b1, 2);
    rd(`TPQ_OFF_QUAD_CNT, 32'h0);
    $display("quadrature test done");
    apb(1'b1, `TPQ_OFF_CTRL, 32'h0300);
    apb(1'b1, `TPQ_OFF_MAIN_CNT, 32'h0);
    apb(1'b1, `TPQ_OFF_PERIOD, 32'h9);
    for (i = 0; i < 3; i++) apb(1'b1, 8'(16 + 4 * i), ev[i]);
    apb(1'b1, `TPQ_OFF_CTRL, 32'h0309);
    for (i = 0; i < 3; i++) begin
      meas(5 - 2 * i, per, hi);
      chk(per, 10);
      chk(hi == ev[i] + 1 || hi == 9 - ev[i], 1);
      meas(4 - 2 * i, per, hin);
      chk(hi + hin, 10);
    end
    meas(5, per, hi);
    apb(1'b1, `TPQ_OFF_CTRL, 32'h0209);
    meas(5, per, hin);
    chk(hin, 10 - hi);
    $display("reset-sync test done");
    apb(1'b1, `TPQ_OFF_CTRL, 32'h0300);
    apb(1'b1, `TPQ_OFF_MAIN_CNT, 32'h2);
    apb(1'b1, `TPQ_OFF_OFFSET_CNT, 32'h0);
    apb(1'b1, `TPQ_OFF_PERIOD, 32'h9);
    for (i = 0; i < 3; i++) apb(1'b1, 8'(16 + 4 * i), cv[i]);
    for (i = 0; i < 3; i++) apb(1'b1, 8'(28 + 4 * i), cv[i]);
    apb(1'b1, `TPQ_OFF_CTRL, 32'h030E);
    meas(5, per, hi);
    chk(per, 14);
    chk(hi, 6);
    meas(4, per, hin);
    chk(hin, 4);
    meas(1, per, hi);
    chk(per, 14);
    c2 = pv[3:2];
    per = 0;
    repeat (40) begin
      @(posedge pclk);
      if (pv[3:2] !== c2) per++;
    end
    chk(per, 0);
    apb(1'b1, `TPQ_OFF_STATUS, 32'h0);
    repeat (20) @(posedge pclk);
    rd(`TPQ_OFF_STATUS, 32'h3);
    apb(1'b1, `TPQ_OFF_BUF1, 32'h4);
    repeat (30) @(posedge pclk);
    rd(`TPQ_OFF_EDGE1, 32'h4);
    meas(5, per, hi);
    chk(hi, 4);
    $display("complementary test done");
    close_out();
  end
endmodule : testbench

// [testbench/tpq_enc_model.sv]
/*
  Quadrature encoder source driving the two phase pins of the timer.
  Assumes one step request at a time, held off while busy is high.
*/
`timescale 1ns/1ns

module tpq_enc_model #(
  parameter int HOLD = 4
) (
  input  wire logic pclk,      // System clock
  input  wire logic step,      // Step request
  input  wire logic dir_up,    // Step direction
  output logic      quad_in_a, // Phase A pin
  output logic      quad_in_b, // Phase B pin
  output logic      busy       // Holding current state
);
  logic [1:0] pos_ff;
  int         wait_ff;

  initial begin
    pos_ff = 2'h0;
    wait_ff = 0;
  end

  // Plain always: the initial block above also writes these variables
  always @(posedge pclk) begin
    if (wait_ff != 0) begin
      wait_ff <= wait_ff - 1;
    end else if (step) begin
      pos_ff <= dir_up ? pos_ff + 2'h1 : pos_ff - 2'h1;
      wait_ff <= HOLD;
    end
  end

  // Gray order 00, 01, 11, 10 on A, B
  assign quad_in_a = pos_ff[1];
  assign quad_in_b = pos_ff[1] ^ pos_ff[0];
  assign busy = wait_ff != 0;
endmodule : tpq_enc_model

// [testbench/tpq_timer_asserts.sv]
/*
  Port checker of tpq_timer, bound into every instance.
  Assumes ctrl changes only through APB writes at offset zero.
*/
`timescale 1ns/1ns
`include "tpq_cfg.svh"

module tpq_timer_chk (
  input wire logic               pclk,     // System clock
  input wire logic               presetn,  // Reset, active low
  input wire logic               ce,       // Clock enable
  input wire logic               psel,     // APB select
  input wire logic               penable,  // APB enable
  input wire logic               pwrite,   // APB write
  input wire logic [`TPQ_AW-1:0] paddr,    // APB address
  input wire logic [31:0]        pwdata,   // Write data
  input wire logic [31:0]        prdata,   // Read data
  input wire logic               pready,   // APB ready
  input wire logic               pslverr,  // APB error
  input wire tpq_pkg::tpq_pwm_s  pwm,      // Phase outputs
  input wire logic               quad_req  // Quad request
);
  logic [15:0] ctrl_ff;
  logic        acc;
  logic        mapped;

  assign acc = psel && penable && ce;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= `TPQ_OFF_QUAD_IRQ_EN;

  // Shadow of the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `TPQ_RST_CTRL;
    end else if (acc && pwrite && paddr == `TPQ_OFF_CTRL) begin
      ctrl_ff <= pwdata[15:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_vals_a: assert property ($rose(presetn) |->
    pwm == 6'h00 && !quad_req && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  ready_ce_a: assert property (psel && penable |-> pready == ce)
    else $error("pready does not follow ce");
  err_addr_a: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  err_rdata_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  freeze_out_a: assert property (!ce |=> $stable(pwm) && $stable(quad_req))
    else $error("outputs moved with ce low");
  irq_off_a: assert property (
    acc && pwrite && paddr == `TPQ_OFF_QUAD_IRQ_EN && pwdata[2:0] == 3'h0
    |-> ##2 (!quad_req || !$past(ce)))
    else $error("quad_req high with enables cleared");
  no_overlap_a: assert property (
    ctrl_ff[1:0] == 2'h2 && ctrl_ff[9:8] == 2'h3 && $stable(ctrl_ff)
    |-> !(pwm.p1 && pwm.p1_n) && !(pwm.p2 && pwm.p2_n)
        && !(pwm.p3 && pwm.p3_n))
    else $error("complementary pair overlaps");
endmodule : tpq_timer_chk

bind tpq_timer tpq_timer_chk u_tpq_timer_chk (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm,
  .quad_req);
